// [verilog/tt16_timers.sv]
// Three 16-bit timers with prescalers, capture on the first two, match/overflow events and an APB slave.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module tt16_timers (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  ext_clock_pin,
  input  wire logic [1:0]  capture_input_pin,
  output logic      [2:0]  match_interrupt,
  output logic      [2:0]  overflow_interrupt,
  output logic             irq
);
  // ********************************************************************
  // Bus decode.
  // ********************************************************************
  typedef enum logic [1:0] {
    TT16_IDLE = 2'b01,
    TT16_DONE = 2'b10
  } tt16_bus_e;
  tt16_bus_e bus_r;
  wire        access   = psel && penable && bus_r == TT16_IDLE;
  wire        addr_ok  = paddr[1:0] == 2'b00;
  wire [23:0] idx      = paddr[25:2];
  wire        wr       = access && pwrite && addr_ok;
  logic [7:0]  ctrl_r  [3];
  logic [7:0]  pre_r   [3];
  logic [15:0] data_r  [3];
  logic [15:0] cnt_r   [3];
  logic [7:0]  pdiv_r  [3];
  logic [7:0]  base_r;
  logic [1:0]  ext_s1_r, ext_s2_r, ext_s3_r;
  logic [1:0]  cap_s1_r, cap_s2_r, cap_s3_r;
  logic [5:0]  stat_r, mask_r;
  logic [31:0] rdat_nxt;
  wire  [2:0]  match_ev, ovf_ev, cap_ev, tick;

  function automatic logic [2:0] mode_of(input int t, input logic [7:0] c);
    if (t == 2) mode_of = {2'b00, c[tt16_pkg::BIT_MODE_L]};
    else mode_of = c[tt16_pkg::BIT_MODE_H:tt16_pkg::BIT_MODE_L];
  endfunction

  function automatic logic is_cap(input logic [2:0] m);
    is_cap = m == tt16_pkg::MODE_CAP_FALL || m == tt16_pkg::MODE_CAP_RISE || m == tt16_pkg::MODE_CAP_BOTH;
  endfunction

  function automatic logic reg_hit(input logic [23:0] a, input logic [23:0] base, input int t);
    reg_hit = a == base + tt16_pkg::IDX_STRIDE * 24'(t);
  endfunction

  // ********************************************************************
  // Base clock divider and external input synchronisers.
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_r <= 8'h00;
    end else begin
      base_r <= base_r + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_r <= 2'h0;
      ext_s2_r <= 2'h0;
      ext_s3_r <= 2'h0;
    end else begin
      ext_s1_r <= ext_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_s1_r <= 2'h0;
      cap_s2_r <= 2'h0;
      cap_s3_r <= 2'h0;
    end else begin
      cap_s1_r <= capture_input_pin;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
    end
  end

  // ********************************************************************
  // Timer datapath.
  // ********************************************************************
  for (genvar t = 0; t < tt16_pkg::NUM_TIMERS; t++) begin : g_tmr
    wire [7:0] c    = ctrl_r[t];
    wire [2:0] mode = mode_of(t, c);
    wire [1:0] ics  = c[tt16_pkg::BIT_ICS_H:tt16_pkg::BIT_ICS_L];
    wire       ext  = (t < 2) && c[tt16_pkg::BIT_SRC];
    wire       base_tick = ics == tt16_pkg::ICS_NONE ? 1'b0 :
                           ics == tt16_pkg::ICS_DIV2 ? (base_r & tt16_pkg::DIV2_MASK) == tt16_pkg::DIV2_MASK :
                           ics == tt16_pkg::ICS_DIV16 ? (base_r & tt16_pkg::DIV16_MASK) == tt16_pkg::DIV16_MASK :
                           base_r == tt16_pkg::DIV256_MASK;
    wire       int_tick = base_tick && pdiv_r[t] == pre_r[t];
    wire       ext_tick = (t < 2) && ext_s2_r[t % 2] && !ext_s3_r[t % 2];
    wire       rise = (t < 2) && cap_s2_r[t % 2] && !cap_s3_r[t % 2];
    wire       fall = (t < 2) && !cap_s2_r[t % 2] && cap_s3_r[t % 2];
    wire       en   = c[tt16_pkg::BIT_EN];
    wire       cwr  = wr && reg_hit(idx, tt16_pkg::IDX_A_CONTROL, t);
    wire       pwr  = wr && reg_hit(idx, tt16_pkg::IDX_A_PRESCALE, t);
    wire       dwr  = wr && reg_hit(idx, tt16_pkg::IDX_A_MATCH, t);
    wire       clr  = cwr && pwdata[tt16_pkg::BIT_CLEAR];
    wire       capm = (t < 2) && is_cap(mode);
    wire       ce   = capm && en && ((mode == tt16_pkg::MODE_CAP_RISE && rise) ||
                      (mode == tt16_pkg::MODE_CAP_FALL && fall) ||
                      (mode == tt16_pkg::MODE_CAP_BOTH && (rise || fall)));
    assign tick[t]     = en && (ext ? ext_tick : int_tick);
    assign match_ev[t] = tick[t] && !capm && cnt_r[t] == data_r[t];
    assign ovf_ev[t]   = tick[t] && cnt_r[t] == tt16_pkg::COUNT_MAX && !match_ev[t]
                         && mode != tt16_pkg::MODE_INTERVAL;
    assign cap_ev[t]   = ce;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctrl_r[t] <= tt16_pkg::RST_CTRL;
      end else if (cwr) begin
        ctrl_r[t] <= {1'b0, pwdata[tt16_pkg::BIT_MODE_H:0]};
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pre_r[t] <= tt16_pkg::RST_PRE;
      end else if (pwr) begin
        pre_r[t] <= pwdata[7:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        data_r[t] <= tt16_pkg::RST_DATA;
      end else if (ce) begin
        data_r[t] <= cnt_r[t];
      end else if (dwr) begin
        data_r[t] <= pwdata[15:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pdiv_r[t] <= 8'h00;
      end else if (!en || clr) begin
        pdiv_r[t] <= 8'h00;
      end else if (base_tick) begin
        pdiv_r[t] <= int_tick ? 8'h00 : pdiv_r[t] + 8'h01;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r[t] <= tt16_pkg::RST_COUNT;
      end else if (clr) begin
        cnt_r[t] <= tt16_pkg::RST_COUNT;
      end else if (match_ev[t] && mode == tt16_pkg::MODE_INTERVAL) begin
        cnt_r[t] <= tt16_pkg::RST_COUNT;
      end else if (tick[t]) begin
        cnt_r[t] <= cnt_r[t] + 16'h0001;
      end
    end
  end

  // ********************************************************************
  // Interrupt status, mask and event pulses.
  // ********************************************************************
  wire [5:0] ev      = {ovf_ev, match_ev};
  wire       st_wr   = wr && idx == tt16_pkg::IDX_IRQ_STATUS;
  wire [5:0] st_nxt  = (stat_r & ~(st_wr ? pwdata[5:0] : 6'h00)) | ev;
  wire       mk_wr   = wr && idx == tt16_pkg::IDX_IRQ_MASK;
  wire [5:0] mk_nxt  = mk_wr ? pwdata[5:0] : mask_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= tt16_pkg::RST_IRQ;
    end else begin
      stat_r <= st_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= tt16_pkg::RST_IRQ;
    end else if (mk_wr) begin
      mask_r <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_interrupt    <= 3'h0;
      overflow_interrupt <= 3'h0;
    end else begin
      match_interrupt    <= match_ev;
      overflow_interrupt <= ovf_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(st_nxt & mk_nxt);
    end
  end

  // ********************************************************************
  // Read mux and APB answer.
  // ********************************************************************
  always_comb begin
    rdat_nxt = 32'h0000_0000;
    for (int t = 0; t < tt16_pkg::NUM_TIMERS; t++) begin
      if (reg_hit(idx, tt16_pkg::IDX_A_CONTROL, t)) rdat_nxt = {24'h0, ctrl_r[t]};
      if (reg_hit(idx, tt16_pkg::IDX_A_PRESCALE, t)) rdat_nxt = {24'h0, pre_r[t]};
      if (reg_hit(idx, tt16_pkg::IDX_A_MATCH, t)) rdat_nxt = {16'h0, data_r[t]};
      if (reg_hit(idx, tt16_pkg::IDX_A_COUNT, t)) rdat_nxt = {16'h0, cnt_r[t]};
    end
    if (idx == tt16_pkg::IDX_IRQ_STATUS) rdat_nxt = {26'h0, stat_r};
    if (idx == tt16_pkg::IDX_IRQ_MASK) rdat_nxt = {26'h0, mask_r};
  end

  wire mapped = addr_ok && (rdat_nxt != 32'h0 || idx == tt16_pkg::IDX_IRQ_STATUS || idx == tt16_pkg::IDX_IRQ_MASK
                || ((idx - tt16_pkg::IDX_A_CONTROL) < 24'h15 && (idx[2:0] == 3'h0 || idx[2:0] == 3'h1
                || idx[2:0] == 3'h2 || idx[2:0] == 3'h4)));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_r   <= TT16_IDLE;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      bus_r   <= access ? TT16_DONE : TT16_IDLE;
      pready  <= access;
      pslverr <= access && !mapped;
      prdata  <= access && !pwrite && mapped ? rdat_nxt : 32'h0000_0000;
    end
  end

  // ********************************************************************
  // Checks.
  // ********************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  interval_restart_a: assert property (match_ev[0] && ctrl_r[0][6:4] == 3'h0 && !wr |=> cnt_r[0] == 16'h0)
    else $error("Interval match did not restart counter.");
  capture_copy_a: assert property (cap_ev[1] |=> data_r[1] == $past(cnt_r[1]))
    else $error("Capture did not copy counter.");
  match_ov_keep_a: assert property (match_ev[0] && ctrl_r[0][6:4] == 3'h1 && !wr |=> cnt_r[0] == $past(cnt_r[0]) + 16'h1)
    else $error("Match cleared counter in match-overflow mode.");
  wrap_zero_a: assert property (ovf_ev[2] && !wr |=> cnt_r[2] == 16'h0 ##0 overflow_interrupt[2])
    else $error("Overflow did not wrap.");
  third_nocap_a: assert property (cap_ev[2] == 1'b0)
    else $error("Third timer captured.");
  clear_bit_a: assert property (wr && idx == 24'h3F0008 && pwdata[7] |=> cnt_r[0] == 16'h0 && !ctrl_r[0][7])
    else $error("Counter clear failed.");
  disabled_hold_a: assert property (!ctrl_r[1][0] && !wr |=> $stable(cnt_r[1]))
    else $error("Disabled counter moved.");
  none_clock_a: assert property (ctrl_r[0][3:2] == 2'h0 && !ctrl_r[0][1] |-> !tick[0])
    else $error("Tick with no base clock.");
  event_pulse_a: assert property (match_interrupt[0] |=> !match_interrupt[0])
    else $error("Match pulse stretched.");
  match_pulse_b_a: assert property (match_interrupt[1] |=> !match_interrupt[1])
    else $error("Second match pulse stretched.");
  match_pulse_c_a: assert property (match_interrupt[2] |=> !match_interrupt[2])
    else $error("Third match pulse stretched.");
  ovf_pulse_a: assert property (overflow_interrupt[0] |=> !overflow_interrupt[0])
    else $error("Overflow pulse stretched.");
  ovf_pulse_b_a: assert property (overflow_interrupt[1] |=> !overflow_interrupt[1])
    else $error("Second overflow pulse stretched.");
  ovf_pulse_c_a: assert property (overflow_interrupt[2] |=> !overflow_interrupt[2])
    else $error("Third overflow pulse stretched.");

  ready_single_a: assert property (pready |=> !pready)
    else $error("Ready held two cycles.");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("Error without ready.");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("Read data outside answer.");
  irq_level_a: assert property (irq == |(stat_r & mask_r))
    else $error("Interrupt level wrong.");
  status_set_a: assert property (match_ev[1] |=> stat_r[1])
    else $error("Match status not set.");
  status_ovf_a: assert property (ovf_ev[0] |=> stat_r[3])
    else $error("Overflow status not set.");
  status_sticky_a: assert property (stat_r[2] && !(wr && idx == tt16_pkg::IDX_IRQ_STATUS && pwdata[2]) |=> stat_r[2])
    else $error("Status bit lost.");
  mask_write_a: assert property (wr && idx == tt16_pkg::IDX_IRQ_MASK |=> mask_r == $past(pwdata[5:0]))
    else $error("Mask write lost.");

  restart_b_a: assert property (match_ev[1] && ctrl_r[1][6:4] == 3'h0 && !wr |=> cnt_r[1] == 16'h0)
    else $error("Second interval match did not restart.");
  restart_c_a: assert property (match_ev[2] && !ctrl_r[2][4] && !wr |=> cnt_r[2] == 16'h0)
    else $error("Third interval match did not restart.");
  interval_no_ovf_a: assert property (ovf_ev[1] |-> ctrl_r[1][6:4] != 3'h0)
    else $error("Overflow in interval mode.");
  ov_keep_c_a: assert property (match_ev[2] && ctrl_r[2][4] && !wr |=> cnt_r[2] == $past(cnt_r[2]) + 16'h1)
    else $error("Third match cleared counter.");
  match_value_a: assert property (match_ev[2] |-> cnt_r[2] == data_r[2])
    else $error("Match without equal count.");

  capture_first_a: assert property (cap_ev[0] |=> data_r[0] == $past(cnt_r[0]))
    else $error("First capture did not copy counter.");
  capture_hold_a: assert property (!cap_ev[1] && !(wr && idx == tt16_pkg::IDX_B_MATCH) |=> $stable(data_r[1]))
    else $error("Captured value not held.");
  capture_nomatch_a: assert property (is_cap(ctrl_r[0][6:4]) |-> !match_ev[0])
    else $error("Match event in capture mode.");
  capture_edge_a: assert property (cap_ev[0] |-> cap_s2_r[0] != cap_s3_r[0])
    else $error("Capture without edge.");
  capture_enable_a: assert property (!ctrl_r[1][0] |-> !cap_ev[1])
    else $error("Capture while disabled.");
  wrap_first_a: assert property (ovf_ev[0] && !wr |=> cnt_r[0] == 16'h0)
    else $error("First timer did not wrap.");
  wrap_second_a: assert property (ovf_ev[1] && !wr |=> cnt_r[1] == 16'h0)
    else $error("Second timer did not wrap.");

  clear_third_a: assert property (wr && idx == tt16_pkg::IDX_C_CONTROL && pwdata[7] |=> cnt_r[2] == 16'h0)
    else $error("Third counter clear failed.");
  clear_zero_a: assert property (wr && idx == tt16_pkg::IDX_A_CONTROL && !pwdata[7] && !ctrl_r[0][0] |=> $stable(cnt_r[0]))
    else $error("Zero clear bit moved counter.");
  hold_first_a: assert property (!ctrl_r[0][0] && !wr |=> $stable(cnt_r[0]))
    else $error("First disabled counter moved.");
  hold_third_a: assert property (!ctrl_r[2][0] && !wr |=> $stable(cnt_r[2]))
    else $error("Third disabled counter moved.");
  count_step_a: assert property (tick[0] && !match_ev[0] && !wr |=> cnt_r[0] == $past(cnt_r[0]) + 16'h1)
    else $error("Counter did not step.");
  count_step_c_a: assert property (tick[2] && !match_ev[2] && !wr |=> cnt_r[2] == $past(cnt_r[2]) + 16'h1)
    else $error("Third counter did not step.");

  prescale_tick_a: assert property (tick[0] && !ctrl_r[0][1] |-> pdiv_r[0] == pre_r[0])
    else $error("Tick before prescale end.");
  div2_tick_a: assert property (ctrl_r[2][0] && ctrl_r[2][3:2] == 2'h1 && pre_r[2] == 8'h00 && pdiv_r[2] == 8'h00
    |-> tick[2] == base_r[0])
    else $error("Divide by two tick wrong.");
  none_clock_c_a: assert property (ctrl_r[2][3:2] == 2'h0 |-> !tick[2])
    else $error("Third tick with no base clock.");
  third_no_ext_a: assert property (ctrl_r[2][1] && ctrl_r[2][3:2] == 2'h0 |-> !tick[2])
    else $error("Third timer counted external clock.");
  ext_tick_a: assert property (tick[1] && ctrl_r[1][1] |-> ext_s2_r[1] && !ext_s3_r[1])
    else $error("External tick without edge.");

  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not one cycle.");
  cover_interval_c: cover property (match_ev[0] && ctrl_r[0][6:4] == 3'h0);
  cover_capture_c: cover property (cap_ev[0] ##[1:50] cap_ev[0]);
  cover_overflow_c: cover property (ovf_ev[1]);
  cover_irq_c: cover property (irq ##1 !irq);
  cover_ext_c: cover property (tick[0] && ctrl_r[0][1]);
endmodule

// [verilog/tt16_pkg.sv]
// Package with register map, field layout and constants of the triple 16-bit timer.
package tt16_pkg;
  // ********************************************************************
  // Register indices (printed offsets are not all word multiples).
  // ********************************************************************
  localparam logic [23:0] IDX_A_CONTROL  = 24'h3F0008;
  localparam logic [23:0] IDX_A_PRESCALE = 24'h3F0009;
  localparam logic [23:0] IDX_A_MATCH    = 24'h3F000A;
  localparam logic [23:0] IDX_A_COUNT    = 24'h3F000C;
  localparam logic [23:0] IDX_B_CONTROL  = 24'h3F0010;
  localparam logic [23:0] IDX_B_PRESCALE = 24'h3F0011;
  localparam logic [23:0] IDX_B_MATCH    = 24'h3F0012;
  localparam logic [23:0] IDX_B_COUNT    = 24'h3F0014;
  localparam logic [23:0] IDX_C_CONTROL  = 24'h3F0018;
  localparam logic [23:0] IDX_C_PRESCALE = 24'h3F0019;
  localparam logic [23:0] IDX_C_MATCH    = 24'h3F001A;
  localparam logic [23:0] IDX_C_COUNT    = 24'h3F001C;
  localparam logic [23:0] IDX_IRQ_STATUS = 24'h3F0020;
  localparam logic [23:0] IDX_IRQ_MASK   = 24'h3F0021;
  localparam logic [23:0] IDX_STRIDE     = 24'h000008;
  // ********************************************************************
  // Control field positions.
  // ********************************************************************
  localparam int BIT_CLEAR  = 7;
  localparam int BIT_MODE_H = 6;
  localparam int BIT_MODE_L = 4;
  localparam int BIT_ICS_H  = 3;
  localparam int BIT_ICS_L  = 2;
  localparam int BIT_SRC    = 1;
  localparam int BIT_EN     = 0;
  // ********************************************************************
  // Mode and clock codes, reset values.
  // ********************************************************************
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_MATCH_OV = 3'h1;
  localparam logic [2:0] MODE_CAP_FALL = 3'h4;
  localparam logic [2:0] MODE_CAP_RISE = 3'h5;
  localparam logic [2:0] MODE_CAP_BOTH = 3'h6;
  localparam logic [1:0] ICS_NONE = 2'h0;
  localparam logic [1:0] ICS_DIV2 = 2'h1;
  localparam logic [1:0] ICS_DIV16 = 2'h2;
  localparam logic [7:0] DIV2_MASK   = 8'h01;
  localparam logic [7:0] DIV16_MASK  = 8'h0F;
  localparam logic [7:0] DIV256_MASK = 8'hFF;
  localparam logic [7:0]  RST_CTRL  = 8'h00;
  localparam logic [7:0]  RST_PRE   = 8'h00;
  localparam logic [15:0] RST_DATA  = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [5:0]  RST_IRQ   = 6'h00;
  localparam int NUM_TIMERS = 3;
endpackage

// [verif/tt16_pins.sv]
// Model of the external count clock and capture pins of the timers.
`timescale 1ns/1ps
module tt16_pins (
  input  wire logic       pclk,
  output logic      [1:0] ext_clock_pin,
  output logic      [1:0] capture_input_pin
);
  // ******************************
  // Pin drivers.
  // ******************************
  initial begin
    ext_clock_pin     = 2'h0;
    capture_input_pin = 2'h0;
  end
  // Each level is held several cycles so the synchroniser sees it.
  task automatic ext_pulses(input int idx, input int cnt);
    repeat (cnt) begin
      @(posedge pclk);
      ext_clock_pin[idx] <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_clock_pin[idx] <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
  task automatic cap_level(input int idx, input logic v);
    @(posedge pclk);
    capture_input_pin[idx] <= v;
    repeat (6) @(posedge pclk);
  endtask
endmodule

// [verif/tt16_timers_tb.sv]
// Self-checking bench of the triple 16-bit timer.
`timescale 1ns/1ps
module tt16_timers_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  ext_clock_pin;
  logic [1:0]  capture_input_pin;
  logic [2:0]  match_interrupt;
  logic [2:0]  overflow_interrupt;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic        err;
  logic [23:0] reg_idx [14];
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          n;
  tt16_timers tt16_timers_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_pin(ext_clock_pin), .capture_input_pin(capture_input_pin),
    .match_interrupt(match_interrupt), .overflow_interrupt(overflow_interrupt), .irq(irq));
  tt16_pins tt16_pins_i (.pclk(pclk), .ext_clock_pin(ext_clock_pin), .capture_input_pin(capture_input_pin));
  // ******************************
  // Clock, timeout and helpers.
  // ******************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [23:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {6'h00, idx, 2'h0};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_match(input int idx);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (match_interrupt[idx] !== 1'b1);
  endtask
  // ******************************
  // Stimulus.
  // ******************************
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
    reg_idx = '{tt16_pkg::IDX_A_CONTROL, tt16_pkg::IDX_A_PRESCALE, tt16_pkg::IDX_A_MATCH, tt16_pkg::IDX_A_COUNT,
      tt16_pkg::IDX_B_CONTROL, tt16_pkg::IDX_B_PRESCALE, tt16_pkg::IDX_B_MATCH, tt16_pkg::IDX_B_COUNT,
      tt16_pkg::IDX_C_CONTROL, tt16_pkg::IDX_C_PRESCALE, tt16_pkg::IDX_C_MATCH, tt16_pkg::IDX_C_COUNT,
      tt16_pkg::IDX_IRQ_STATUS, tt16_pkg::IDX_IRQ_MASK};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (reg_idx[i]) begin
      apb(1'b0, reg_idx[i], 32'h0);
      check(rd, 32'h0);
      check({31'h0, err}, 32'h0);
    end
    apb(1'b0, 24'h3F0040, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, tt16_pkg::IDX_A_PRESCALE, 32'hA5);
    apb(1'b0, tt16_pkg::IDX_A_PRESCALE, 32'h0);
    check(rd, 32'hA5);
    apb(1'b1, tt16_pkg::IDX_A_PRESCALE, 32'h0);
    apb(1'b1, tt16_pkg::IDX_C_COUNT, 32'h55);
    apb(1'b0, tt16_pkg::IDX_C_COUNT, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, tt16_pkg::IDX_C_MATCH, 32'h3);
    apb(1'b1, tt16_pkg::IDX_C_PRESCALE, 32'h1);
    apb(1'b1, tt16_pkg::IDX_C_CONTROL, 32'h84);
    apb(1'b0, tt16_pkg::IDX_C_CONTROL, 32'h0);
    check(rd, 32'h04);
    apb(1'b1, tt16_pkg::IDX_C_CONTROL, 32'h05);
    wait_match(2);
    wait_match(2);
    check(32'(n), 32'd16);
    apb(1'b1, tt16_pkg::IDX_IRQ_MASK, 32'h04);
    apb(1'b0, tt16_pkg::IDX_IRQ_STATUS, 32'h0);
    check(rd & 32'h04, 32'h04);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, tt16_pkg::IDX_C_CONTROL, 32'h04);
    apb(1'b1, tt16_pkg::IDX_IRQ_STATUS, 32'h04);
    apb(1'b0, tt16_pkg::IDX_IRQ_STATUS, 32'h0);
    check(rd & 32'h04, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, tt16_pkg::IDX_C_CONTROL, 32'h81);
    repeat (20) @(posedge pclk);
    apb(1'b0, tt16_pkg::IDX_C_COUNT, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, tt16_pkg::IDX_A_MATCH, 32'h2);
    apb(1'b1, tt16_pkg::IDX_A_CONTROL, 32'h92);
    apb(1'b1, tt16_pkg::IDX_A_CONTROL, 32'h13);
    tt16_pins_i.ext_pulses(0, 3);
    repeat (6) @(posedge pclk);
    apb(1'b0, tt16_pkg::IDX_A_COUNT, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, tt16_pkg::IDX_IRQ_STATUS, 32'h0);
    check(rd & 32'h09, 32'h01);
    check({29'h0, overflow_interrupt}, 32'h0);
    apb(1'b1, tt16_pkg::IDX_B_CONTROL, 32'hD4);
    apb(1'b1, tt16_pkg::IDX_B_CONTROL, 32'h55);
    repeat (40) @(posedge pclk);
    tt16_pins_i.cap_level(1, 1'b1);
    apb(1'b0, tt16_pkg::IDX_B_MATCH, 32'h0);
    rd2 = rd;
    apb(1'b0, tt16_pkg::IDX_B_COUNT, 32'h0);
    check({31'h0, rd2 != 32'h0 && rd2 < rd}, 32'h1);
    tt16_pins_i.cap_level(1, 1'b0);
    apb(1'b0, tt16_pkg::IDX_B_MATCH, 32'h0);
    check(rd, rd2);
    apb(1'b1, tt16_pkg::IDX_B_CONTROL, 32'h65);
    tt16_pins_i.cap_level(1, 1'b1);
    apb(1'b0, tt16_pkg::IDX_B_MATCH, 32'h0);
    check({31'h0, rd != rd2}, 32'h1);
    rd2 = rd;
    apb(1'b1, tt16_pkg::IDX_B_CONTROL, 32'h45);
    tt16_pins_i.cap_level(1, 1'b0);
    apb(1'b0, tt16_pkg::IDX_B_MATCH, 32'h0);
    check({31'h0, rd != rd2}, 32'h1);
    apb(1'b1, tt16_pkg::IDX_B_CONTROL, 32'h44);
    apb(1'b0, tt16_pkg::IDX_B_COUNT, 32'h0);
    rd2 = rd;
    repeat (10) @(posedge pclk);
    apb(1'b0, tt16_pkg::IDX_B_COUNT, 32'h0);
    check(rd, rd2);
    stop_test();
  end
endmodule
